// ### hdl/mcuasd_map.vh
// register addresses, field positions, reset values and operation codes
// of the core arithmetic/status datapath; included by the alu, the checker and the bench
`ifndef MCUASD_MAP_VH
`define MCUASD_MAP_VH

// special function space addresses
`define MCUASD_PSW_ADDR 8'hd0
`define MCUASD_ACC_ADDR 8'he0
`define MCUASD_AUX_ADDR 8'hf0
// bit-address groups (address bits 7:3)
`define MCUASD_PSW_BGRP 5'h1a
`define MCUASD_ACC_BGRP 5'h1c
`define MCUASD_AUX_BGRP 5'h1e

// reset values
`define MCUASD_PSW_RST 7'h00
`define MCUASD_ACC_RST 8'h00
`define MCUASD_AUX_RST 8'h00

// processor_state_word fields
`define MCUASD_CARRY 7
`define MCUASD_HALF 6
`define MCUASD_UF0 5
`define MCUASD_BSH 4
`define MCUASD_BSL 3
`define MCUASD_WRAP 2
`define MCUASD_UF1 1
`define MCUASD_PAR 0

// byte operations
`define MCUASD_OP_NOP 5'h00
`define MCUASD_OP_ADD 5'h01
`define MCUASD_OP_ADDC 5'h02
`define MCUASD_OP_SUBB 5'h03
`define MCUASD_OP_INC 5'h04
`define MCUASD_OP_DEC 5'h05
`define MCUASD_OP_MUL 5'h06
`define MCUASD_OP_DIV 5'h07
`define MCUASD_OP_DA 5'h08
`define MCUASD_OP_CMP 5'h09
`define MCUASD_OP_AND 5'h0a
`define MCUASD_OP_OR 5'h0b
`define MCUASD_OP_XOR 5'h0c
`define MCUASD_OP_CPL 5'h0d
`define MCUASD_OP_CLR 5'h0e
`define MCUASD_OP_RL 5'h0f
`define MCUASD_OP_RLC 5'h10
`define MCUASD_OP_RR 5'h11
`define MCUASD_OP_RRC 5'h12
`define MCUASD_OP_SWAP 5'h13
`define MCUASD_OP_MOV 5'h14

// bit operations
`define MCUASD_BOP_NONE 4'h0
`define MCUASD_BOP_SET 4'h1
`define MCUASD_BOP_CLR 4'h2
`define MCUASD_BOP_CPL 4'h3
`define MCUASD_BOP_JSET 4'h4
`define MCUASD_BOP_JCLR 4'h5
`define MCUASD_BOP_JSETCLR 4'h6
`define MCUASD_BOP_TOCY 4'h7
`define MCUASD_BOP_FROMCY 4'h8
`define MCUASD_BOP_ANDCY 4'h9
`define MCUASD_BOP_ORCY 4'ha
`define MCUASD_BOP_ANDNCY 4'hb
`define MCUASD_BOP_ORNCY 4'hc

`endif

// ### hdl/mcuasd_muldiv.v
// unsigned 8x8 multiply and 8/8 divide for the datapath
// assumes operands are stable flip-flop outputs of the same clock
`timescale 1ns/1ps
`default_nettype none
module mcuasd_muldiv (
  input wire [7:0] dividend_i,
  input wire [7:0] divisor_i,
  output wire [15:0] product_o,
  output wire [7:0] quotient_o,
  output wire [7:0] remainder_o,
  output wire mul_wrap_o,
  output wire div_zero_o
);

  assign product_o = {8'h00, dividend_i} * {8'h00, divisor_i};
  // wrap flag when product needs the high byte
  assign mul_wrap_o = (product_o[15:8] != 8'h00);
  assign div_zero_o = (divisor_i == 8'h00);
  // divide by zero: keep operands, caller leaves acc and aux untouched
  assign quotient_o = div_zero_o ? dividend_i : (dividend_i / divisor_i);
  assign remainder_o = div_zero_o ? divisor_i : (dividend_i % divisor_i);

endmodule // mcuasd_muldiv
`default_nettype wire

// ### hdl/mcuasd_alu.v
// arithmetic, logic and bit datapath with accumulator, aux operand and status word
// assumes the decoder issues one operation per cycle and drives the special
// function bus on the same clock; bit reads from outside come from same-clock logic
`timescale 1ns/1ps
`default_nettype none
`include "mcuasd_map.vh"
module mcuasd_alu (
  input wire clock_i,
  input wire arst_n_i,
  input wire alu_go_i,
  input wire [4:0] alu_op_i,
  input wire a_sel_acc_i,
  input wire dst_acc_i,
  input wire [7:0] opnd_a_i,
  input wire [7:0] opnd_b_i,
  input wire bit_go_i,
  input wire [3:0] bit_op_i,
  input wire [7:0] bit_addr_i,
  input wire bit_rdata_i,
  input wire [7:0] sfr_addr_i,
  input wire sfr_we_i,
  input wire [7:0] sfr_wdata_i,
  input wire sfr_re_i,
  output wire [7:0] sfr_rdata_o,
  output wire sfr_hit_o,
  output wire [7:0] acc_o,
  output wire [7:0] aux_o,
  output wire [7:0] psw_o,
  output wire [7:0] result_o,
  output wire branch_o,
  output wire bit_we_o,
  output wire bit_wdata_o,
  output wire [7:0] bit_waddr_o,
  output wire [7:0] bank_base_o
);

  ////////////////////////////////////////////////////////////////////////////
  // reset release
  reg [1:0] rst_sync_q;
  wire rst_n;

  always @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      rst_sync_q <= 2'b00;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n = rst_sync_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // state
  reg [7:0] acc_q, acc_d;
  reg [7:0] aux_q, aux_d;
  reg [7:1] psw_q, psw_d;
  reg [7:0] res_q, res_d;
  reg [7:0] rdata_q, rdata_d;
  reg br_q, br_d;
  reg bwe_q, bwe_d;
  reg bwd_q, bwd_d;
  reg [7:0] bwa_q, bwa_d;
  wire [7:0] psw_v;
  wire [15:0] md_prod;
  wire [7:0] md_quot;
  wire [7:0] md_rem;
  wire md_wrap;
  wire md_zero;

  assign psw_v = {psw_q, ^acc_q};

  mcuasd_muldiv u_muldiv (
    .dividend_i(acc_q),
    .divisor_i(aux_q),
    .product_o(md_prod),
    .quotient_o(md_quot),
    .remainder_o(md_rem),
    .mul_wrap_o(md_wrap),
    .div_zero_o(md_zero)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic
  reg [7:0] a;
  reg cin;
  reg [8:0] sum9;
  reg [4:0] sum5;
  reg [7:0] sum8;
  reg [8:0] dif9;
  reg [4:0] dif5;
  reg [8:0] da9;
  reg da_c;
  reg [7:0] val;
  reg wr_val;
  reg bv;
  reg bwr;
  reg nb;
  reg bint;

  always @*
  begin
    a = a_sel_acc_i ? acc_q : opnd_a_i;
    cin = 1'b0;
    sum9 = 9'h000;
    sum5 = 5'h00;
    sum8 = 8'h00;
    dif9 = 9'h000;
    dif5 = 5'h00;
    da9 = 9'h000;
    da_c = 1'b0;
    val = 8'h00;
    wr_val = 1'b0;
    bv = 1'b0;
    bwr = 1'b0;
    nb = 1'b0;
    bint = 1'b0;
    acc_d = acc_q;
    aux_d = aux_q;
    psw_d = psw_q;
    res_d = res_q;
    rdata_d = rdata_q;
    br_d = 1'b0;
    bwe_d = 1'b0;
    bwd_d = bwd_q;
    bwa_d = bwa_q;

    // direct-address writes, ops below take priority in a clash
    if (sfr_we_i)
    begin
      if (sfr_addr_i == `MCUASD_ACC_ADDR)
        acc_d = sfr_wdata_i;
      else if (sfr_addr_i == `MCUASD_AUX_ADDR)
        aux_d = sfr_wdata_i;
      else if (sfr_addr_i == `MCUASD_PSW_ADDR)
        psw_d = sfr_wdata_i[7:1];
    end

    if (alu_go_i)
    begin
      cin = ((alu_op_i == `MCUASD_OP_ADDC) || (alu_op_i == `MCUASD_OP_SUBB)) ?
            psw_q[`MCUASD_CARRY] : 1'b0;
      sum9 = {1'b0, a} + {1'b0, opnd_b_i} + {8'h00, cin};
      sum5 = {1'b0, a[3:0]} + {1'b0, opnd_b_i[3:0]} + {4'h0, cin};
      sum8 = {1'b0, a[6:0]} + {1'b0, opnd_b_i[6:0]} + {7'h00, cin};
      dif9 = {1'b0, a} - {1'b0, opnd_b_i} - {8'h00, cin};
      dif5 = {1'b0, a[3:0]} - {1'b0, opnd_b_i[3:0]} - {4'h0, cin};
      case (alu_op_i)
        // add with carry, half carry and wrap
        `MCUASD_OP_ADD, `MCUASD_OP_ADDC:
        begin
          val = sum9[7:0];
          wr_val = 1'b1;
          psw_d[`MCUASD_CARRY] = sum9[8];
          psw_d[`MCUASD_HALF] = sum5[4];
          psw_d[`MCUASD_WRAP] = sum9[8] ^ sum8[7];
        end
        `MCUASD_OP_SUBB:
        begin
          val = dif9[7:0];
          wr_val = 1'b1;
          psw_d[`MCUASD_CARRY] = dif9[8];
          psw_d[`MCUASD_HALF] = dif5[4];
          psw_d[`MCUASD_WRAP] = (a[7] ^ opnd_b_i[7]) & (a[7] ^ dif9[7]);
        end
        // inc and dec leave every flag alone
        `MCUASD_OP_INC:
        begin
          val = a + 8'h01;
          wr_val = 1'b1;
        end
        `MCUASD_OP_DEC:
        begin
          val = a - 8'h01;
          wr_val = 1'b1;
        end
        // product low byte to accumulator, high byte to aux
        `MCUASD_OP_MUL:
        begin
          acc_d = md_prod[7:0];
          aux_d = md_prod[15:8];
          psw_d[`MCUASD_CARRY] = 1'b0;
          psw_d[`MCUASD_WRAP] = md_wrap;
        end
        // quotient to accumulator, remainder to aux
        `MCUASD_OP_DIV:
        begin
          psw_d[`MCUASD_CARRY] = 1'b0;
          psw_d[`MCUASD_WRAP] = md_zero;
          if (!md_zero)
          begin
            acc_d = md_quot;
            aux_d = md_rem;
          end
        end
        // decimal adjust, carry only ever set
        `MCUASD_OP_DA:
        begin
          da9 = {1'b0, acc_q};
          if ((acc_q[3:0] > 4'h9) || psw_q[`MCUASD_HALF])
            da9 = da9 + 9'h006;
          da_c = psw_q[`MCUASD_CARRY] | da9[8];
          if ((da9[7:4] > 4'h9) || da_c)
            da9 = {1'b0, da9[7:0]} + 9'h060;
          acc_d = da9[7:0];
          psw_d[`MCUASD_CARRY] = da_c | da9[8];
        end
        // compare: borrow into carry, branch when unequal
        `MCUASD_OP_CMP:
        begin
          psw_d[`MCUASD_CARRY] = (a < opnd_b_i);
          br_d = (a != opnd_b_i);
        end
        `MCUASD_OP_AND:
        begin
          val = a & opnd_b_i;
          wr_val = 1'b1;
        end
        `MCUASD_OP_OR:
        begin
          val = a | opnd_b_i;
          wr_val = 1'b1;
        end
        `MCUASD_OP_XOR:
        begin
          val = a ^ opnd_b_i;
          wr_val = 1'b1;
        end
        `MCUASD_OP_CPL:
          acc_d = ~acc_q;
        `MCUASD_OP_CLR:
          acc_d = 8'h00;
        `MCUASD_OP_RL:
          acc_d = {acc_q[6:0], acc_q[7]};
        `MCUASD_OP_RR:
          acc_d = {acc_q[0], acc_q[7:1]};
        `MCUASD_OP_RLC:
        begin
          acc_d = {acc_q[6:0], psw_q[`MCUASD_CARRY]};
          psw_d[`MCUASD_CARRY] = acc_q[7];
        end
        `MCUASD_OP_RRC:
        begin
          acc_d = {psw_q[`MCUASD_CARRY], acc_q[7:1]};
          psw_d[`MCUASD_CARRY] = acc_q[0];
        end
        `MCUASD_OP_SWAP:
          acc_d = {acc_q[3:0], acc_q[7:4]};
        `MCUASD_OP_MOV:
        begin
          val = opnd_b_i;
          wr_val = 1'b1;
        end
        default:
          val = 8'h00;
      endcase
      if (wr_val)
      begin
        res_d = val;
        if (dst_acc_i)
          acc_d = val;
      end
    end
    else if (bit_go_i)
    begin
      // bits of own registers are reached by bit address
      bint = 1'b1;
      if (bit_addr_i[7:3] == `MCUASD_PSW_BGRP)
        bv = psw_v[bit_addr_i[2:0]];
      else if (bit_addr_i[7:3] == `MCUASD_ACC_BGRP)
        bv = acc_q[bit_addr_i[2:0]];
      else if (bit_addr_i[7:3] == `MCUASD_AUX_BGRP)
        bv = aux_q[bit_addr_i[2:0]];
      else
      begin
        bv = bit_rdata_i;
        bint = 1'b0;
      end
      case (bit_op_i)
        `MCUASD_BOP_SET:
        begin
          nb = 1'b1;
          bwr = 1'b1;
        end
        `MCUASD_BOP_CLR:
          bwr = 1'b1;
        `MCUASD_BOP_CPL:
        begin
          nb = ~bv;
          bwr = 1'b1;
        end
        `MCUASD_BOP_JSET:
          br_d = bv;
        `MCUASD_BOP_JCLR:
          br_d = ~bv;
        `MCUASD_BOP_JSETCLR:
        begin
          br_d = bv;
          bwr = bv;
        end
        `MCUASD_BOP_TOCY:
          psw_d[`MCUASD_CARRY] = bv;
        `MCUASD_BOP_FROMCY:
        begin
          nb = psw_q[`MCUASD_CARRY];
          bwr = 1'b1;
        end
        `MCUASD_BOP_ANDCY:
          psw_d[`MCUASD_CARRY] = psw_q[`MCUASD_CARRY] & bv;
        `MCUASD_BOP_ORCY:
          psw_d[`MCUASD_CARRY] = psw_q[`MCUASD_CARRY] | bv;
        `MCUASD_BOP_ANDNCY:
          psw_d[`MCUASD_CARRY] = psw_q[`MCUASD_CARRY] & ~bv;
        `MCUASD_BOP_ORNCY:
          psw_d[`MCUASD_CARRY] = psw_q[`MCUASD_CARRY] | ~bv;
        default:
          nb = 1'b0;
      endcase
      if (bwr && bint)
      begin
        // parity is not storable, a write to it is dropped
        if (bit_addr_i[7:3] == `MCUASD_ACC_BGRP)
          acc_d[bit_addr_i[2:0]] = nb;
        else if (bit_addr_i[7:3] == `MCUASD_AUX_BGRP)
          aux_d[bit_addr_i[2:0]] = nb;
        else if (bit_addr_i[2:0] != 3'd`MCUASD_PAR)
          psw_d[bit_addr_i[2:0]] = nb;
      end
      else if (bwr)
      begin
        bwe_d = 1'b1;
        bwd_d = nb;
        bwa_d = bit_addr_i;
      end
    end

    // registered read data, read of parity sees current acc
    if (sfr_re_i)
    begin
      if (sfr_addr_i == `MCUASD_ACC_ADDR)
        rdata_d = acc_q;
      else if (sfr_addr_i == `MCUASD_AUX_ADDR)
        rdata_d = aux_q;
      else if (sfr_addr_i == `MCUASD_PSW_ADDR)
        rdata_d = psw_v;
      else
        rdata_d = 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers
  always @(posedge clock_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      acc_q <= `MCUASD_ACC_RST;
      aux_q <= `MCUASD_AUX_RST;
      psw_q <= `MCUASD_PSW_RST;
      res_q <= 8'h00;
      rdata_q <= 8'h00;
      br_q <= 1'b0;
      bwe_q <= 1'b0;
      bwd_q <= 1'b0;
      bwa_q <= 8'h00;
    end
    else
    begin
      acc_q <= acc_d;
      aux_q <= aux_d;
      psw_q <= psw_d;
      res_q <= res_d;
      rdata_q <= rdata_d;
      br_q <= br_d;
      bwe_q <= bwe_d;
      bwd_q <= bwd_d;
      bwa_q <= bwa_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign sfr_hit_o = (sfr_addr_i == `MCUASD_ACC_ADDR) || (sfr_addr_i == `MCUASD_AUX_ADDR) ||
                     (sfr_addr_i == `MCUASD_PSW_ADDR);
  assign sfr_rdata_o = rdata_q;
  assign acc_o = acc_q;
  assign aux_o = aux_q;
  assign psw_o = psw_v;
  assign result_o = res_q;
  assign branch_o = br_q;
  assign bit_we_o = bwe_q;
  assign bit_wdata_o = bwd_q;
  assign bit_waddr_o = bwa_q;
  assign bank_base_o = {3'b000, psw_q[`MCUASD_BSH], psw_q[`MCUASD_BSL], 3'b000};

endmodule // mcuasd_alu
`default_nettype wire

// ### tb/mcuasd_alu_chk.sv
// port assertions for the arithmetic/status datapath
// assumes one core clock and the async active-low reset input
`timescale 1ns/1ps
`default_nettype none
`include "mcuasd_map.vh"
module mcuasd_alu_chk (
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic alu_go_i,
  input wire logic [4:0] alu_op_i,
  input wire logic bit_go_i,
  input wire logic [3:0] bit_op_i,
  input wire logic [7:0] bit_addr_i,
  input wire logic bit_rdata_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_we_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic sfr_re_i,
  input wire logic [7:0] sfr_rdata_o,
  input wire logic sfr_hit_o,
  input wire logic [7:0] acc_o,
  input wire logic [7:0] aux_o,
  input wire logic [7:0] psw_o,
  input wire logic branch_o,
  input wire logic bit_we_o,
  input wire logic bit_wdata_o,
  input wire logic [7:0] bank_base_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);
  //////////////////////////////////////////////////////////////////////////////
  // parity follows acc
  property p_par; psw_o[0] == ^acc_o; endproperty
  a_par: assert property (p_par) else $error("parity bit differs from acc");
  property p_bank; bank_base_o == {3'h0, psw_o[4:3], 3'h0}; endproperty
  a_bank: assert property (p_bank) else $error("bank base wrong");
  property p_hit; sfr_hit_o == (sfr_addr_i == `MCUASD_PSW_ADDR
    || sfr_addr_i == `MCUASD_ACC_ADDR || sfr_addr_i == `MCUASD_AUX_ADDR); endproperty
  a_hit: assert property (p_hit) else $error("hit decode wrong");
  // direct write to acc, no op competing
  property p_accwr; sfr_we_i && sfr_addr_i == `MCUASD_ACC_ADDR && !alu_go_i && !bit_go_i
    |=> acc_o == $past(sfr_wdata_i); endproperty
  a_accwr: assert property (p_accwr) else $error("acc write lost");
  property p_auxwr; sfr_we_i && sfr_addr_i == `MCUASD_AUX_ADDR && !alu_go_i && !bit_go_i
    |=> aux_o == $past(sfr_wdata_i); endproperty
  a_auxwr: assert property (p_auxwr) else $error("aux write lost");
  property p_rd; sfr_re_i && sfr_addr_i == `MCUASD_AUX_ADDR |=> sfr_rdata_o == $past(aux_o);
  endproperty
  a_rd: assert property (p_rd) else $error("aux read wrong");
  property p_rd0; sfr_re_i && !sfr_hit_o |=> sfr_rdata_o == 8'h00; endproperty
  a_rd0: assert property (p_rd0) else $error("unmapped read not zero");
  // multiply splits product over aux and acc
  property p_mul; alu_go_i && alu_op_i == `MCUASD_OP_MUL |=> {aux_o, acc_o} ==
    $past(acc_o) * $past(aux_o) && !psw_o[7] && psw_o[2] == (aux_o != 8'h00); endproperty
  a_mul: assert property (p_mul) else $error("multiply result wrong");
  // branch on set bit and clear it in the same cycle, both drop the next
  sequence s_jsc_go;
    bit_go_i && !alu_go_i && bit_op_i == `MCUASD_BOP_JSETCLR && bit_addr_i < 8'hd0 && bit_rdata_i;
  endsequence
  sequence s_jsc_done;
    branch_o && bit_we_o && !bit_wdata_o ##1 !branch_o && !bit_we_o;
  endsequence
  property p_jsc; s_jsc_go |=> s_jsc_done; endproperty
  a_jsc: assert property (p_jsc) else $error("set-and-clear branch wrong");
endmodule // mcuasd_alu_chk
`default_nettype wire

// ### tb/mcuasd_bit_space.sv
// model of the external bit-addressable registers behind the bit port
// assumes writes come as one-cycle pulses on the core clock
`timescale 1ns/1ps
`default_nettype none
module mcuasd_bit_space (
  input wire logic clock_i,
  input wire logic [7:0] bit_addr_i,
  input wire logic bit_we_i,
  input wire logic bit_wdata_i,
  input wire logic [7:0] bit_waddr_i,
  output logic bit_rdata_o
);
  logic [255:0] bits_q = 256'h0;
  always @(posedge clock_i)
    if (bit_we_i)
      bits_q[bit_waddr_i] <= bit_wdata_i;
  // same-cycle answer, as the core expects
  assign bit_rdata_o = bits_q[bit_addr_i];
endmodule // mcuasd_bit_space
`default_nettype wire

// ### tb/mcuasd_alu_status_datapath_tb.sv
// self-checking bench for the datapath with an external bit model
// assumes inputs change at the falling edge, one clock
`timescale 1ns/1ps
`default_nettype none
`include "mcuasd_map.vh"
module mcuasd_alu_status_datapath_tb;
  typedef struct packed {logic [4:0] op; logic [7:0] a, b, ps, ea; logic ec;} mcuasd_row_t;
  logic clock_i = 1'h0, arst_n_i = 1'h0, alu_go_i = 1'h0, bit_go_i = 1'h0;
  logic sfr_we_i = 1'h0, sfr_re_i = 1'h0, a_sel_acc_i = 1'h1, dst_acc_i = 1'h1;
  logic [7:0] opnd_a_i = 8'h00;
  logic [4:0] alu_op_i = 5'h00;
  logic [3:0] bit_op_i = 4'h0;
  logic [7:0] opnd_b_i = 8'h00, bit_addr_i = 8'h00, sfr_addr_i = 8'h00, sfr_wdata_i = 8'h00;
  wire [7:0] sfr_rdata_o, acc_o, aux_o, psw_o, result_o, bit_waddr_o, bank_base_o;
  wire sfr_hit_o, branch_o, bit_we_o, bit_wdata_o, bit_rdata_i;
  int error_cnt = 0, checked = 0;
  mcuasd_row_t rows [19] = '{
    '{`MCUASD_OP_CMP, 8'h02, 8'h02, 8'h80, 8'h02, 1'h0},
    '{`MCUASD_OP_ADD, 8'hff, 8'h01, 8'h00, 8'h00, 1'h1},
    '{`MCUASD_OP_ADDC, 8'h01, 8'h01, 8'h80, 8'h03, 1'h0},
    '{`MCUASD_OP_SUBB, 8'h10, 8'h20, 8'h00, 8'hf0, 1'h1},
    '{`MCUASD_OP_INC, 8'hff, 8'h00, 8'h80, 8'h00, 1'h1},
    '{`MCUASD_OP_DEC, 8'h00, 8'h00, 8'h00, 8'hff, 1'h0},
    '{`MCUASD_OP_DA, 8'h1a, 8'h00, 8'h00, 8'h20, 1'h0},
    '{`MCUASD_OP_CMP, 8'h01, 8'h02, 8'h00, 8'h01, 1'h1},
    '{`MCUASD_OP_AND, 8'hf0, 8'h3c, 8'h00, 8'h30, 1'h0},
    '{`MCUASD_OP_OR, 8'hf0, 8'h0f, 8'h80, 8'hff, 1'h1},
    '{`MCUASD_OP_XOR, 8'hff, 8'h0f, 8'h00, 8'hf0, 1'h0},
    '{`MCUASD_OP_CPL, 8'h55, 8'h00, 8'h00, 8'haa, 1'h0},
    '{`MCUASD_OP_CLR, 8'h55, 8'h00, 8'h00, 8'h00, 1'h0},
    '{`MCUASD_OP_RL, 8'h81, 8'h00, 8'h00, 8'h03, 1'h0},
    '{`MCUASD_OP_RLC, 8'h80, 8'h00, 8'h00, 8'h00, 1'h1},
    '{`MCUASD_OP_RR, 8'h01, 8'h00, 8'h00, 8'h80, 1'h0},
    '{`MCUASD_OP_RRC, 8'h01, 8'h00, 8'h80, 8'h80, 1'h1},
    '{`MCUASD_OP_SWAP, 8'h12, 8'h00, 8'h00, 8'h21, 1'h0},
    '{`MCUASD_OP_MOV, 8'h00, 8'h5a, 8'h00, 8'h5a, 1'h0}};
  //////////////////////////////////////////////////////////////////////////////
  // operand A source and destination are driven per scenario
  mcuasd_alu dut (.clock_i, .arst_n_i, .alu_go_i, .alu_op_i, .a_sel_acc_i,
    .dst_acc_i, .opnd_a_i, .opnd_b_i, .bit_go_i, .bit_op_i, .bit_addr_i,
    .bit_rdata_i, .sfr_addr_i, .sfr_we_i, .sfr_wdata_i, .sfr_re_i, .sfr_rdata_o, .sfr_hit_o,
    .acc_o, .aux_o, .psw_o, .result_o, .branch_o, .bit_we_o, .bit_wdata_o, .bit_waddr_o,
    .bank_base_o);
  mcuasd_bit_space u_bits (.clock_i, .bit_addr_i, .bit_we_i(bit_we_o),
    .bit_wdata_i(bit_wdata_o), .bit_waddr_i(bit_waddr_o), .bit_rdata_o(bit_rdata_i));
  initial
    forever #5 clock_i = ~clock_i;
  //////////////////////////////////////////////////////////////////////////////
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e)
    begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      error_cnt++;
    end
  endtask
  task automatic sfr_wr(input logic [7:0] ad, input logic [7:0] d);
    @(negedge clock_i);
    {sfr_we_i, sfr_addr_i, sfr_wdata_i} = {1'h1, ad, d};
    @(negedge clock_i);
    sfr_we_i = 1'h0;
  endtask
  task automatic sfr_rd(input logic [7:0] ad, input logic [7:0] e);
    @(negedge clock_i);
    {sfr_re_i, sfr_addr_i} = {1'h1, ad};
    @(negedge clock_i);
    sfr_re_i = 1'h0;
    chk("read data", e, sfr_rdata_o);
  endtask
  task automatic alu(input logic [4:0] op, input logic [7:0] b);
    @(negedge clock_i);
    {alu_go_i, alu_op_i, opnd_b_i} = {1'h1, op, b};
    @(negedge clock_i);
    alu_go_i = 1'h0;
  endtask
  task automatic bop(input logic [3:0] op, input logic [7:0] ad, input logic e);
    @(negedge clock_i);
    {bit_go_i, bit_op_i, bit_addr_i} = {1'h1, op, ad};
    @(negedge clock_i);
    bit_go_i = 1'h0;
    chk("branch", {7'h0, e}, {7'h0, branch_o});
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20000) @(posedge clock_i);
    error_cnt++;
    end_sim();
  end
  initial
  begin
    repeat (20) @(negedge clock_i);
    arst_n_i = 1'h1;
    repeat (3) @(negedge clock_i);
    sfr_rd(`MCUASD_ACC_ADDR, 8'h00);
    sfr_rd(`MCUASD_PSW_ADDR, 8'h00);
    sfr_rd(`MCUASD_AUX_ADDR, 8'h00);
    foreach (rows[i])
    begin
      sfr_wr(`MCUASD_ACC_ADDR, rows[i].a);
      sfr_wr(`MCUASD_PSW_ADDR, rows[i].ps);
      alu(rows[i].op, rows[i].b);
      chk("acc", rows[i].ea, acc_o);
      chk("carry", {7'h0, rows[i].ec}, {7'h0, psw_o[7]});
      chk("parity", {7'h0, ^rows[i].ea}, {7'h0, psw_o[0]});
      chk("cmp branch", {7'h0, rows[i].op == `MCUASD_OP_CMP && rows[i].a != rows[i].b},
        {7'h0, branch_o});
      if (rows[i].op inside {`MCUASD_OP_ADD, `MCUASD_OP_ADDC, `MCUASD_OP_SUBB, `MCUASD_OP_INC,
          `MCUASD_OP_DEC, `MCUASD_OP_AND, `MCUASD_OP_OR, `MCUASD_OP_XOR, `MCUASD_OP_MOV})
        chk("result", rows[i].ea, result_o);
    end
    // multiply and divide through the aux register, divide by zero last
    sfr_wr(`MCUASD_ACC_ADDR, 8'h20);
    sfr_wr(`MCUASD_AUX_ADDR, 8'h10);
    sfr_wr(`MCUASD_PSW_ADDR, 8'h80);
    alu(`MCUASD_OP_MUL, 8'h00);
    chk("mul psw", 8'h04, psw_o);
    sfr_rd(`MCUASD_AUX_ADDR, 8'h02);
    sfr_wr(`MCUASD_ACC_ADDR, 8'hfb);
    sfr_wr(`MCUASD_AUX_ADDR, 8'h10);
    alu(`MCUASD_OP_DIV, 8'h00);
    chk("quotient", 8'h0f, acc_o);
    chk("remainder", 8'h0b, aux_o);
    sfr_wr(`MCUASD_AUX_ADDR, 8'h00);
    alu(`MCUASD_OP_DIV, 8'h00);
    chk("div zero psw", 8'h04, psw_o);
    chk("div zero acc", 8'h0f, acc_o);
    // bank codes, acc cleared so parity stays low
    sfr_wr(`MCUASD_ACC_ADDR, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      sfr_wr(`MCUASD_PSW_ADDR, 8'(i << 3));
      chk("bank base", 8'(i << 3), bank_base_o);
      sfr_rd(`MCUASD_PSW_ADDR, 8'(i << 3));
    end
    // user flags survive an add that sets carry and half carry
    sfr_wr(`MCUASD_ACC_ADDR, 8'hff);
    sfr_wr(`MCUASD_PSW_ADDR, 8'h22);
    alu(`MCUASD_OP_ADD, 8'h01);
    chk("flags", 8'he2, psw_o);
    sfr_wr(`MCUASD_PSW_ADDR, 8'h00);
    sfr_wr(`MCUASD_AUX_ADDR, 8'h00);
    bop(`MCUASD_BOP_SET, 8'he3, 1'h0);
    chk("acc bit set", 8'h08, acc_o);
    bop(`MCUASD_BOP_CPL, 8'he3, 1'h0);
    bop(`MCUASD_BOP_CPL, 8'he0, 1'h0);
    chk("acc bit cpl", 8'h01, acc_o);
    bop(`MCUASD_BOP_TOCY, 8'he0, 1'h0);
    bop(`MCUASD_BOP_FROMCY, 8'hf7, 1'h0);
    chk("aux from carry", 8'h80, aux_o);
    bop(`MCUASD_BOP_CLR, 8'hf7, 1'h0);
    chk("aux bit clr", 8'h00, aux_o);
    bop(`MCUASD_BOP_JSET, 8'he0, 1'h1);
    bop(`MCUASD_BOP_JCLR, 8'he0, 1'h0);
    // external bit through the model: set, take and clear, then miss
    bop(`MCUASD_BOP_SET, 8'h20, 1'h0);
    chk("bit write addr", 8'h20, bit_waddr_o);
    bop(`MCUASD_BOP_JSETCLR, 8'h20, 1'h1);
    bop(`MCUASD_BOP_JSETCLR, 8'h20, 1'h0);
    bop(`MCUASD_BOP_JCLR, 8'h20, 1'h1);
    // unmapped address neither stores nor answers
    sfr_wr(8'h80, 8'hff);
    chk("acc after stray write", 8'h01, acc_o);
    sfr_rd(8'h80, 8'h00);
    // outside operand, result kept out of acc
    {a_sel_acc_i, dst_acc_i, opnd_a_i} = {1'h0, 1'h0, 8'h30};
    alu(`MCUASD_OP_ADD, 8'h05);
    chk("outside result", 8'h35, result_o);
    chk("acc kept", 8'h01, acc_o);
    {a_sel_acc_i, dst_acc_i} = 2'h3;
    // second reset in mid-run clears at once
    @(negedge clock_i);
    arst_n_i = 1'h0;
    #1;
    chk("acc in reset", 8'h00, acc_o);
    chk("psw in reset", 8'h00, psw_o);
    repeat (3) @(negedge clock_i);
    arst_n_i = 1'h1;
    repeat (3) @(negedge clock_i);
    sfr_rd(`MCUASD_AUX_ADDR, 8'h00);
    end_sim();
  end
endmodule // mcuasd_alu_status_datapath_tb
bind mcuasd_alu mcuasd_alu_chk u_chk (.clock_i, .arst_n_i, .alu_go_i, .alu_op_i, .bit_go_i,
  .bit_op_i, .bit_addr_i, .bit_rdata_i, .sfr_addr_i, .sfr_we_i, .sfr_wdata_i, .sfr_re_i,
  .sfr_rdata_o, .sfr_hit_o, .acc_o, .aux_o, .psw_o, .branch_o, .bit_we_o, .bit_wdata_o,
  .bank_base_o);
`default_nettype wire
